// ===== logic/cmd_decode.sv
// two-cycle command decoder, init tracker and sleep control
`default_nettype none
// What this block does
// - ready 200 clocks after extended mode load; no access before (not enforced: opens still decode while O_READY is low).
// - extended load, mode load and refreshes accepted in any order.
// - cs low, function_select high opens a row for reading.
// - cs low, function_select low opens a row for writing.
// - second command comes on the very next clock edge.
// - sixteen-bit column is address 6..0, bit 7 ignored.
// - eight-bit column is address 7..0.
// - write open then cs low, power_down_n high: auto-refresh.
// - read open then cs low, address 14..8 low: mode load.
// - write open then refresh with power_down_n low: self-refresh.
// - power_down_n low with cs high from idle enters power-down.
// - power_down_n rising exits sleep asynchronously.
// - other inputs sampled on the rising clock edge.
// - write column carries write length controls on upper bits.
// - write length code selects words written per burst.
// - low pair governs low byte lane, high pair high lane; eight-bit copies the low pair to the high lane.
// - activation during a burst is illegal; deselect continues.
module cmd_decode
  import cmd_decode_pkg::*;
#(
  parameter int X16 = 1
) (
  // clock and reset
  input  wire logic        I_CLK,
  input  wire logic        I_RST,
  // command pins
  input  wire logic        I_CS_N,
  input  wire logic        I_FUNCTION_SELECT,
  input  wire logic        I_POWER_DOWN_N,
  input  wire logic [1:0]  I_BANK,
  input  wire logic [14:0] I_ADDR,
  // decoded access
  output var  access_t     O_ACCESS,
  output logic             O_REFRESH,
  output logic             O_ILLEGAL,
  // mode and status
  output logic [9:0]       O_MODE_REG,
  output logic [9:0]       O_EXT_MODE_REG,
  output logic             O_READY,
  output logic             O_POWER_DOWN,
  output logic             O_SELF_REFRESH,
  output state_t           O_STATE
);

  if (!(X16 == 0 || X16 == 1)) begin : g_bad_org
    $error("X16 must be 0 or 1");
  end

  pins_t  pin_s1_reg, pin_s2_reg;
  logic   awake_prev_reg;
  state_t state_reg, state_next;
  logic [7:0] cnt_reg, cnt_next;
  logic [7:0] ready_cnt_reg;
  logic   ext_done_reg, mode_done_reg;
  logic [1:0] ref_cnt_reg;
  logic [1:0] open_bank_reg;
  logic [14:0] open_row_reg;
  logic   wake_tog_reg, wake_s1_reg, wake_s2_reg, wake_s3_reg;

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      pin_s1_reg  <= '{cs_n: 1'b1, power_down_n: 1'b0, default: '0};
      pin_s2_reg  <= '{cs_n: 1'b1, power_down_n: 1'b0, default: '0};
      awake_prev_reg <= 1'b0;
    end else begin
      pin_s1_reg  <= '{cs_n: I_CS_N, function_select: I_FUNCTION_SELECT,
                       power_down_n: I_POWER_DOWN_N, bank: I_BANK,
                       addr: I_ADDR};
      pin_s2_reg  <= pin_s1_reg;
      awake_prev_reg <= pin_s2_reg.power_down_n;
    end
  end

  // async exit
  // the rising pin edge itself flips a toggle, so a stopped clock in
  // self-refresh cannot lose the exit event
  always_ff @(posedge I_POWER_DOWN_N or posedge I_RST) begin
    if (I_RST) wake_tog_reg <= 1'b0;
    else wake_tog_reg <= ~wake_tog_reg;
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      wake_s1_reg <= 1'b0;
      wake_s2_reg <= 1'b0;
      wake_s3_reg <= 1'b0;
    end else begin
      wake_s1_reg <= wake_tog_reg;
      wake_s2_reg <= wake_s1_reg;
      wake_s3_reg <= wake_s2_reg;
    end
  end

  wire logic wake_evt = wake_s2_reg ^ wake_s3_reg;
  wire pins_t cur = pin_s2_reg;
  wire logic awake = cur.power_down_n;
  wire logic desel = cur.cs_n & awake;
  wire logic sel = ~cur.cs_n & awake;
  wire logic read_open = sel & cur.function_select;
  wire logic write_open = sel & ~cur.function_select;
  wire logic bl4 = O_MODE_REG[ML_LEN_LSB +: 3] == BURST_CODE_4;
  wire logic cl4 = O_MODE_REG[ML_LAT_LSB +: 3] == LAT_CODE_4;
  wire logic [7:0] refc_cycles = cl4 ? 8'(REFC_CL4) : 8'(REFC_CL3);
  wire logic [7:0] burst_cycles =
    8'(O_MODE_REG[ML_LAT_LSB +: 3]) + (bl4 ? 8'h02 : 8'h01);
  wire logic mode_hit = ~cur.cs_n & awake & (cur.addr[14:8] == 7'h00);
  wire logic [7:0] col = (X16 != 0) ? {1'b0, cur.addr[6:0]}
                                    : cur.addr[7:0];

  function automatic logic [3:0] words(input logic b4, input logic c0,
                                       input logic c1);
    logic [3:0] w;
    w = 4'h0;
    if (!b4) w = c0 ? 4'h1 : 4'h3;
    else if (c0 && !c1) w = 4'hF;
    else if (!c0 && c1) w = 4'h3;
    else if (c0 && c1) w = 4'h1;
    return w;
  endfunction

  wire logic [3:0] low_w = words(bl4, cur.addr[LOW_CTL0_BIT],
                                 cur.addr[LOW_CTL1_BIT]);
  wire logic [3:0] high_w = (X16 != 0)
    ? words(bl4, cur.addr[HIGH_CTL0_BIT], cur.addr[HIGH_CTL1_BIT])
    : low_w;
  // reserved burst-four code writes nothing; flagged only when on the low pair
  wire logic wl_reserved = bl4 & ~cur.addr[LOW_CTL0_BIT]
                         & ~cur.addr[LOW_CTL1_BIT];

  logic col_go, is_wr, ref_go, mode_go, bad;

  always_comb begin
    state_next = state_reg;
    cnt_next = (cnt_reg != 8'h00) ? cnt_reg - 8'h01 : 8'h00;
    col_go = 1'b0;
    is_wr = 1'b0;
    ref_go = 1'b0;
    mode_go = 1'b0;
    bad = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (read_open) state_next = ST_READ_OPEN;
        else if (write_open) state_next = ST_WRITE_OPEN;
        else if (awake_prev_reg && !awake && cur.cs_n)
          state_next = ST_POWER_DOWN;
        else if (!awake && !cur.cs_n) bad = 1'b1;
      end
      ST_READ_OPEN: begin
        state_next = ST_IDLE;
        if (desel) begin
          col_go = 1'b1;
          state_next = ST_READ_BURST;
          cnt_next = burst_cycles;
        end else if (mode_hit) begin
          mode_go = 1'b1;
          state_next = ST_MODE_ACCESS;
          cnt_next = 8'(RSC_CYCLES);
        end else if (!awake) bad = 1'b1;
      end
      ST_WRITE_OPEN: begin
        state_next = ST_IDLE;
        if (desel) begin
          col_go = 1'b1;
          is_wr = 1'b1;
          bad = wl_reserved;
          state_next = ST_WRITE_BURST;
          cnt_next = burst_cycles;
        end else if (sel) begin
          ref_go = 1'b1;
          state_next = ST_REFRESHING;
          cnt_next = refc_cycles;
        end else if (!cur.cs_n) begin
          ref_go = 1'b1;
          state_next = ST_SELF_REFRESH;
        end else bad = 1'b1;
      end
      ST_READ_BURST, ST_WRITE_BURST: begin
        if (sel || !awake) bad = 1'b1;
        if (cnt_reg <= 8'h01) state_next = ST_IDLE;
      end
      ST_REFRESHING: begin
        if (!awake && cur.cs_n) state_next = ST_SELF_REFRESH;
        else if (sel || !awake) bad = 1'b1;
        else if (cnt_reg <= 8'h01) state_next = ST_IDLE;
      end
      ST_MODE_ACCESS: begin
        if (sel || !awake) bad = 1'b1;
        if (cnt_reg <= 8'h01) state_next = ST_IDLE;
      end
      ST_POWER_DOWN: begin
        if (wake_evt) begin
          state_next = ST_WAKING;
          cnt_next = 8'(WAKE_CYCLES);
        end
      end
      ST_SELF_REFRESH: begin
        if (wake_evt) begin
          state_next = ST_WAKING;
          cnt_next = refc_cycles;
        end
      end
      ST_WAKING: begin
        if (cnt_reg <= 8'h01) state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 8'h00;
      open_bank_reg <= 2'h0;
      open_row_reg <= 15'h0000;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      if (read_open || write_open) begin
        open_bank_reg <= cur.bank;
        open_row_reg <= cur.addr;
      end
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_ACCESS <= '0;
      O_REFRESH <= 1'b0;
      O_ILLEGAL <= 1'b0;
    end else begin
      O_ACCESS.col_valid <= col_go;
      O_REFRESH <= ref_go;
      O_ILLEGAL <= bad;
      if (col_go) begin
        O_ACCESS.is_write <= is_wr;
        O_ACCESS.bank <= open_bank_reg;
        O_ACCESS.row_bits <= open_row_reg;
        O_ACCESS.column_bits <= col;
        O_ACCESS.low_words <= is_wr ? low_w : 4'hF;
        O_ACCESS.high_words <= is_wr ? high_w : 4'hF;
      end
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_MODE_REG <= MODE_RESET;
      O_EXT_MODE_REG <= EXT_RESET;
      ext_done_reg <= 1'b0;
      mode_done_reg <= 1'b0;
      ref_cnt_reg <= 2'h0;
    end else begin
      // op-code from bank, bit 7 and bits 6..0
      if (mode_go && cur.bank[EXT_SEL_BIT]) begin
        O_EXT_MODE_REG <= {cur.bank, cur.addr[7:0]};
        ext_done_reg <= 1'b1;
      end else if (mode_go) begin
        O_MODE_REG <= {cur.bank, cur.addr[7:0]};
        mode_done_reg <= 1'b1;
      end
      if (ref_go && ref_cnt_reg != 2'(REF_MIN_INIT))
        ref_cnt_reg <= ref_cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) ready_cnt_reg <= 8'h00;
    else if (mode_go && cur.bank[EXT_SEL_BIT]) ready_cnt_reg <= 8'h00;
    else if (ext_done_reg && ready_cnt_reg != 8'(READY_CLOCKS))
      ready_cnt_reg <= ready_cnt_reg + 8'h01;
  end

  assign O_READY = ext_done_reg & mode_done_reg
                 & (ref_cnt_reg == 2'(REF_MIN_INIT))
                 & (ready_cnt_reg == 8'(READY_CLOCKS));
  assign O_POWER_DOWN = state_reg == ST_POWER_DOWN;
  assign O_SELF_REFRESH = state_reg == ST_SELF_REFRESH;
  assign O_STATE = state_reg;

  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);

  chk_read_second: assert property (
    state_reg == ST_READ_OPEN |=> state_reg != ST_READ_OPEN)
    else $error("read open held past one cycle");
  chk_read_column: assert property (
    state_reg == ST_READ_OPEN && desel |=>
      O_ACCESS.col_valid && !O_ACCESS.is_write)
    else $error("read column not issued");
  chk_refresh_go: assert property (
    state_reg == ST_WRITE_OPEN && sel |=> O_REFRESH
      && state_reg == ST_REFRESHING)
    else $error("auto-refresh not started");
  chk_self_entry: assert property (
    state_reg == ST_WRITE_OPEN && !cur.cs_n && !awake |=> O_SELF_REFRESH)
    else $error("self-refresh not entered");
  chk_mode_load: assert property (
    state_reg == ST_READ_OPEN && mode_hit && !cur.bank[EXT_SEL_BIT] |=>
      O_MODE_REG == {$past(cur.bank), $past(cur.addr[7:0])})
    else $error("mode register not loaded");
  chk_sleep_entry: assert property (
    state_reg == ST_IDLE && awake_prev_reg && !awake && cur.cs_n |=>
      O_POWER_DOWN)
    else $error("power-down not entered");
  chk_wake_exit: assert property (
    O_POWER_DOWN && wake_evt |=> state_reg == ST_WAKING
      ##2 state_reg == ST_IDLE)
    else $error("power-down exit timing wrong");
  chk_burst_bad: assert property (
    state_reg == ST_READ_BURST && sel |=> O_ILLEGAL)
    else $error("activation during burst not flagged");
  chk_ready_wait: assert property (
    $rose(ext_done_reg) |-> !O_READY [*8])
    else $error("ready too soon after extended load");
  chk_wl_full: assert property (
    state_reg == ST_WRITE_OPEN && desel && bl4
      && cur.addr[LOW_CTL0_BIT] && !cur.addr[LOW_CTL1_BIT] |=>
      O_ACCESS.low_words == 4'hF)
    else $error("write length decode wrong");

  cov_read: cover property (state_reg == ST_READ_OPEN ##1
    state_reg == ST_READ_BURST);
  cov_self: cover property (O_SELF_REFRESH ##[1:50] state_reg == ST_IDLE);
  cov_ready: cover property ($rose(O_READY));

endmodule // cmd_decode
`default_nettype wire

// ===== logic/cmd_decode_pkg.sv
// shared constants and types for the two-cycle command decoder
`default_nettype none
package cmd_decode_pkg;
  localparam int ADDR_W = 15;
  localparam int BANK_W = 2;
  // clock rate and documented cycle counts
  localparam int CLK_MHZ = 10;
  localparam int READY_CLOCKS = 200;
  localparam int REFC_CL3 = 15;
  localparam int REFC_CL4 = 18;
  localparam int RSC_CYCLES = 5;
  localparam int WAKE_CYCLES = 2;
  localparam int REF_MIN_INIT = 2;
  // mode register op-code layout
  localparam int ML_LAT_LSB = 4;
  localparam int ML_ORDER_BIT = 3;
  localparam int ML_LEN_LSB = 0;
  localparam int EXT_SEL_BIT = 0;
  localparam logic [2:0] BURST_CODE_2 = 3'h1;
  localparam logic [2:0] BURST_CODE_4 = 3'h2;
  localparam logic [2:0] LAT_CODE_3 = 3'h3;
  localparam logic [2:0] LAT_CODE_4 = 3'h4;
  localparam logic [9:0] MODE_RESET = 10'h032;
  localparam logic [9:0] EXT_RESET = 10'h000;
  // write length address bits
  localparam int LOW_CTL0_BIT = 14;
  localparam int LOW_CTL1_BIT = 13;
  localparam int HIGH_CTL0_BIT = 12;
  localparam int HIGH_CTL1_BIT = 11;

  typedef struct packed {
    logic                cs_n;
    logic                function_select;
    logic                power_down_n;
    logic [BANK_W-1:0]   bank;
    logic [ADDR_W-1:0]   addr;
  } pins_t;

  typedef struct packed {
    logic       col_valid;
    logic       is_write;
    logic [1:0] bank;
    logic [14:0] row_bits;
    logic [7:0] column_bits;
    logic [3:0] low_words;
    logic [3:0] high_words;
  } access_t;

  typedef enum logic [3:0] {
    ST_IDLE, ST_READ_OPEN, ST_WRITE_OPEN, ST_READ_BURST,
    ST_WRITE_BURST, ST_REFRESHING, ST_MODE_ACCESS,
    ST_POWER_DOWN, ST_SELF_REFRESH, ST_WAKING
  } state_t;
endpackage
`default_nettype wire

// ===== testbench/cmd_decode_tb_top.sv
// self-checking bench for the two-cycle command decoder
`default_nettype none
module cmd_decode_tb_top;
  import cmd_decode_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  typedef struct packed {
    logic        fsel;
    logic [1:0]  bank;
    logic [14:0] row;
    logic [14:0] col;
    logic [7:0]  ecol;
    logic [3:0]  elo;
    logic [3:0]  ehi;
  } row_t;

  logic        clk, rst, cs_n, fsel, pwr_n;
  logic [1:0]  bank;
  logic [14:0] addr;
  access_t     acc, acc8;
  logic        refresh, illegal, ready, pdown, sref;
  logic [9:0]  mreg, ereg;
  state_t      state;
  int          fail_count, num_checks, cycles;
  // read, then writes over all three legal four-word length codes
  row_t        rows [4] = '{
    '{1'h1, 2'h2, 15'h1234, 15'h00FF, 8'h7F, 4'hF, 4'hF},
    '{1'h0, 2'h1, 15'h7FFF, 15'h4855, 8'h55, 4'hF, 4'h3},
    '{1'h0, 2'h3, 15'h0001, 15'h702A, 8'h2A, 4'h1, 4'hF},
    '{1'h0, 2'h0, 15'h4AAA, 15'h387F, 8'h7F, 4'h3, 4'h1}};

  ctl_model ctl (.clk(clk), .cs_n(cs_n), .fsel(fsel), .pwr_n(pwr_n),
                 .bank(bank), .addr(addr));

  cmd_decode #(.X16(1)) uut (
    .I_CLK(clk), .I_RST(rst), .I_CS_N(cs_n), .I_FUNCTION_SELECT(fsel),
    .I_POWER_DOWN_N(pwr_n), .I_BANK(bank), .I_ADDR(addr),
    .O_ACCESS(acc), .O_REFRESH(refresh), .O_ILLEGAL(illegal),
    .O_MODE_REG(mreg), .O_EXT_MODE_REG(ereg), .O_READY(ready),
    .O_POWER_DOWN(pdown), .O_SELF_REFRESH(sref), .O_STATE(state));

  // eight-bit organisation, watched on column and lane fields only
  cmd_decode #(.X16(0)) uut_x8 (
    .I_CLK(clk), .I_RST(rst), .I_CS_N(cs_n), .I_FUNCTION_SELECT(fsel),
    .I_POWER_DOWN_N(pwr_n), .I_BANK(bank), .I_ADDR(addr),
    .O_ACCESS(acc8), .O_REFRESH(), .O_ILLEGAL(), .O_MODE_REG(),
    .O_EXT_MODE_REG(), .O_READY(), .O_POWER_DOWN(), .O_SELF_REFRESH(),
    .O_STATE());

  initial begin
    clk = 1'h0;
    forever #50 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic conclude;
    if (fail_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // a whole run is near 2500 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 8000) begin
      fail_count++;
      conclude();
    end
  end

  function automatic logic pick(input int w);
    case (w)
      0: pick = acc.col_valid;
      1: pick = refresh;
      2: pick = illegal;
      3: pick = pdown;
      4: pick = sref;
      6: pick = ready;
      7: pick = acc.col_valid | refresh | illegal;
      default: pick = (state == ST_IDLE);
    endcase
  endfunction

  // pulses stand one cycle, so every edge is looked at
  task automatic wait_ev(input int w, input int n, input logic [31:0] e,
                         input string nm);
    logic got;
    got = 1'h0;
    for (int i = 0; i < n && got !== 1'h1; i++) begin
      @(posedge clk);
      #1;
      if (pick(w) === 1'h1) got = 1'h1;
    end
    chk(nm, got, e);
  endtask

  // refresh spacing stays far above the average floor
  task automatic settle;
    repeat (3) @(posedge clk);
    wait_ev(5, 60, 1, "idle");
  endtask

  task automatic refresh_op;
    ctl.op(1'h0, 2'h3, 15'h0000, 1'h0, 1'h1, 2'h3, 15'h7FFF);
    wait_ev(1, 8, 1, "refresh");
    settle();
  endtask

  task automatic mode_op(input logic [1:0] b, input logic [7:0] opc);
    ctl.op(1'h1, 2'h2, 15'h7FFF, 1'h0, 1'h1, b, {7'h00, opc});
    settle();
  endtask

  initial begin
    {rst, fail_count, num_checks, cycles} = {1'h1, 96'h0};
    repeat (16) @(posedge clk);
    #1;
    chk("mode reset", mreg, 10'h032);
    chk("ext reset", ereg, 10'h000);
    chk("ready reset", ready, 1'h0);
    chk("state reset", state, ST_IDLE);
    @(negedge clk) rst = 1'h0;
    repeat (2000) @(posedge clk);
    ctl.drive(1'h1, 1'h0, 1'h1, 2'h0, 15'h0000);
    refresh_op();
    mode_op(2'h0, 8'h42);
    chk("mode load", mreg, 10'h042);
    mode_op(2'h1, 8'h5A);
    chk("ext load", ereg, 10'h15A);
    refresh_op();
    repeat (140) @(posedge clk);
    chk("early ready", ready, 1'h0);
    wait_ev(6, 80, 1, "ready");
    foreach (rows[i]) begin
      ctl.op(rows[i].fsel, rows[i].bank, rows[i].row, 1'h1, 1'h1,
             ~rows[i].bank, rows[i].col);
      wait_ev(0, 8, 1, "col_valid");
      chk("is_write", acc.is_write, !rows[i].fsel);
      chk("bank", acc.bank, rows[i].bank);
      chk("row", acc.row_bits, rows[i].row);
      chk("column", acc.column_bits, rows[i].ecol);
      chk("low words", acc.low_words, rows[i].elo);
      chk("high words", acc.high_words, rows[i].ehi);
      chk("x8 high words", acc8.high_words, rows[i].elo);
      if (i == 0) chk("x8 column", acc8.column_bits, 8'hFF);
      settle();
    end
    // reserved four-word length code
    ctl.op(1'h0, 2'h1, 15'h0100, 1'h1, 1'h1, 2'h2, 15'h0005);
    wait_ev(2, 8, 1, "reserved");
    settle();
    chk("reserved words", acc.low_words, 4'h0);
    // activation while a read burst runs
    ctl.op(1'h1, 2'h0, 15'h0002, 1'h1, 1'h1, 2'h3, 15'h0011);
    ctl.drive(1'h0, 1'h1, 1'h1, 2'h1, 15'h0003);
    ctl.drive(1'h1, 1'h0, 1'h1, 2'h2, 15'h7FFC);
    wait_ev(2, 10, 1, "burst activation");
    settle();
    // uncovered second-cycle code
    ctl.op(1'h1, 2'h2, 15'h0004, 1'h0, 1'h1, 2'h1, 15'h0122);
    wait_ev(7, 8, 0, "no-op pulse");
    settle();
    // power-down code right after a read opening is refused
    ctl.op(1'h1, 2'h2, 15'h0004, 1'h1, 1'h0, 2'h1, 15'h0022);
    wait_ev(2, 8, 1, "read-open sleep code");
    settle();
    // power-down from idle, held while low
    ctl.drive(1'h1, 1'h1, 1'h0, 2'h0, 15'h0000);
    wait_ev(3, 8, 1, "power-down");
    repeat (10) @(posedge clk);
    chk("power-down held", pdown, 1'h1);
    // wake on the rising edge of power_down_n
    ctl.drive(1'h1, 1'h0, 1'h1, 2'h3, 15'h7FFF);
    settle();
    chk("power-down exit", pdown, 1'h0);
    ctl.op(1'h0, 2'h2, 15'h0005, 1'h0, 1'h0, 2'h2, 15'h0000);
    wait_ev(1, 8, 1, "retention refresh");
    repeat (30) @(posedge clk);
    chk("retention held", sref, 1'h1);
    ctl.drive(1'h1, 1'h1, 1'h1, 2'h1, 15'h7FFF);
    settle();
    chk("retention exit", sref, 1'h0);
    // two-word bursts, first word only in both lanes
    mode_op(2'h0, 8'h31);
    chk("mode two-word", mreg, 10'h031);
    ctl.op(1'h0, 2'h3, 15'h0006, 1'h1, 1'h1, 2'h0, 15'h5012);
    wait_ev(0, 8, 1, "col_valid");
    chk("column two-word", acc.column_bits, 8'h12);
    chk("low two-word", acc.low_words, 4'h1);
    chk("high two-word", acc.high_words, 4'h1);
    settle();
    conclude();
  end
endmodule // cmd_decode_tb_top
`default_nettype wire

// ===== testbench/ctl_model.sv
// memory controller model that issues two-cycle commands
`default_nettype none
module ctl_model (
  // clock
  input  wire logic        clk,
  // command pins
  output logic             cs_n,
  output logic             fsel,
  output logic             pwr_n,
  output logic [1:0]       bank,
  output logic [14:0]      addr
);
  timeunit 1ns;
  timeprecision 1ns;

  // deselected, power_down_n low until the bench wakes it
  initial begin
    {cs_n, fsel, pwr_n, bank, addr} = {3'h4, 2'h0, 15'h0000};
  end

  task automatic drive(input logic c, input logic f, input logic p,
                       input logic [1:0] b, input logic [14:0] a);
    @(negedge clk);
    {cs_n, fsel, pwr_n, bank, addr} = {c, f, p, b, a};
  endtask

  // second half on the very next edge, pd_n from p2 with it
  // released lines show the inverse so stale values never match
  task automatic op(input logic f, input logic [1:0] b,
                    input logic [14:0] r, input logic c2, input logic p2,
                    input logic [1:0] b2, input logic [14:0] a2);
    drive(1'h0, f, 1'h1, b, r);
    drive(c2, f, p2, b2, a2);
    drive(1'h1, ~f, c2 | p2, ~b2, ~a2);
  endtask
endmodule // ctl_model
`default_nettype wire
